/* common/rtci_pkg.sv */
// constants and helpers shared by the rtc interrupt source block
// assumes a 100 mhz core clock; no other package is needed
package rtci_pkg;

    // -----------------------------------------------------------------
    // clock and periodic timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    localparam int PER_MIN_US = 122;
    // fastest periodic interval, rounded down as a longest time
    localparam int PER_BASE_CYC = PER_MIN_US * NS_PER_US / CLK_PERIOD_NS;

    // -----------------------------------------------------------------
    // periodic rate table
    // -----------------------------------------------------------------
    localparam int RATE_W = 4;
    localparam int MULT_W = 19;
    localparam logic [RATE_W-1:0] RATE_LAST_SHIFT = 4'hd;
    localparam logic [RATE_W-1:0] RATE_10S = 4'he;
    localparam logic [MULT_W-1:0] MULT_ONE = 19'h00001;
    localparam logic [MULT_W-1:0] MULT_10S = 19'h14000;
    localparam logic [MULT_W-1:0] MULT_60S = 19'h78000;

    // -----------------------------------------------------------------
    // sources and time fields
    // -----------------------------------------------------------------
    localparam int SRC_NUM = 3;
    localparam int SRC_ALM = 0;
    localparam int SRC_PER = 1;
    localparam int SRC_UPD = 2;
    localparam int BCD_W = 8;
    localparam int FIELD_NUM = 4;

    typedef enum logic {RTCI_IDLE, RTCI_RUN} rtci_gen_state_t;

    // base intervals per periodic rate: 2^n up to one second, then 10 s
    // and one minute; sixteen fixed choices and nothing in between
    function automatic logic [MULT_W-1:0] rtci_rate_mult(
        input logic [RATE_W-1:0] sel
    );
        logic [MULT_W-1:0] m;
        m = MULT_60S;
        if (sel <= RATE_LAST_SHIFT) begin
            m = MULT_ONE << sel;
        end else if (sel == RATE_10S) begin
            m = MULT_10S;
        end
        return m;
    endfunction : rtci_rate_mult

    // alarm compare: a field whose care bit is low always matches, so
    // the repeat period spans one second (no care) to one week (all)
    function automatic logic rtci_alarm_match(
        input logic [FIELD_NUM*BCD_W-1:0] now,
        input logic [FIELD_NUM*BCD_W-1:0] alm,
        input logic [FIELD_NUM-1:0] care
    );
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < FIELD_NUM; i++) begin
            if (care[i] &&
                now[i*BCD_W +: BCD_W] != alm[i*BCD_W +: BCD_W]) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction : rtci_alarm_match

endpackage : rtci_pkg

/* core/rtci_rate_gen.sv */
// periodic tick generator for the rtc interrupt sources
// assumes a synchronous reset copy and same-clock control inputs
`timescale 1ns/1ps
module rtci_rate_gen import rtci_pkg::*; #(
    parameter int BASE_CYC = PER_BASE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_sync_n,
    input wire logic run,
    input wire logic [RATE_W-1:0] rate_sel,
    output logic tick
);
    localparam int PRE_W = $clog2(BASE_CYC + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(BASE_CYC - 1);

    typedef struct packed {
        rtci_gen_state_t state;
        logic [PRE_W-1:0] pre;
        logic [MULT_W-1:0] mult;
        logic [RATE_W-1:0] sel;
        logic tick;
    } rtci_gen_t;

    rtci_gen_t cur;
    rtci_gen_t next_cur;
    logic [MULT_W-1:0] lim;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    // a rate change restarts the interval so no odd short period leaks
    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        next_cur.sel = rate_sel;
        lim = rtci_rate_mult(cur.sel); // [R5]
        unique case (cur.state)
            RTCI_IDLE: begin
                next_cur.pre = '0;
                next_cur.mult = '0;
                if (run) begin
                    next_cur.state = RTCI_RUN;
                end
            end
            RTCI_RUN: begin
                if (!run || rate_sel != cur.sel) begin
                    next_cur.state = RTCI_IDLE; // [R4]
                    next_cur.pre = '0;
                    next_cur.mult = '0;
                end else if (cur.pre == PRE_LAST) begin
                    next_cur.pre = '0;
                    if (cur.mult == lim - MULT_ONE) begin
                        next_cur.mult = '0;
                        next_cur.tick = 1'b1; // [R4]
                    end else begin
                        next_cur.mult = cur.mult + MULT_ONE;
                    end
                end else begin
                    next_cur.pre = cur.pre + PRE_W'(1);
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick = cur.tick;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    // gap counter, only read by the checks
    logic [39:0] gap;
    logic gap_ok;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            gap <= '0;
            gap_ok <= 1'b0;
        end else if (!run || rate_sel != cur.sel || tick) begin
            gap <= '0;
            gap_ok <= run && tick && rate_sel == cur.sel;
        end else begin
            gap <= gap + 40'h1;
        end
    end

    AST_PER_GAP: assert property (tick && gap_ok |->
        gap == 40'(BASE_CYC) * 40'(rtci_rate_mult(cur.sel)) - 40'h1) // [R5]
        else $error("periodic interval differs from selected rate");
    AST_PER_STOP: assert property (!run |=> ##1 !tick) // [R4]
        else $error("periodic tick while stopped");
endmodule : rtci_rate_gen

/* core/rtci_top.sv */
// rtc interrupt sources: alarm, periodic and update, merged to one line
// assumes all inputs but rst_n come from logic on core_clk; the time
// and alarm buses are bcd and the update strobe is one cycle wide
//
// Contract
// R1 - three sources (alarm, periodic, update) share one interrupt line.
// R2 - the line is high when any enabled source fires; disabled ones never.
// R3 - alarm fires on a time match, repeating from 1 s up to 1 week.
// R4 - periodic fires independent of time and alarm, from 122 us to 1 minute.
// R5 - the periodic interval is one of sixteen fixed rates only.
// R6 - update fires once per second as the stored time advances.
// R7 - time and alarm values are bcd, one digit per nibble.
// R8 - software reads and writes the time so an update cannot corrupt it. Not done here: this block only takes time_now as an input.
// R9 - each source keeps its own pending flag to tell software the cause.
`timescale 1ns/1ps
module rtci_top import rtci_pkg::*; #(
    parameter int BASE_CYC = PER_BASE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic alarm_en,
    input wire logic periodic_en,
    input wire logic update_en,
    input wire logic [RATE_W-1:0] rate_sel,
    input wire logic update_strobe,
    input wire logic [FIELD_NUM*BCD_W-1:0] time_now,
    input wire logic [FIELD_NUM*BCD_W-1:0] alarm_time,
    input wire logic [FIELD_NUM-1:0] alarm_care,
    input wire logic alarm_clr,
    input wire logic periodic_clr,
    input wire logic update_clr,
    output logic rtc_irq,
    output logic alarm_pend,
    output logic periodic_pend,
    output logic update_pend
);
    typedef struct packed {
        logic alm_chk;
        logic [SRC_NUM-1:0] pend;
        logic irq;
    } rtci_state_t;

    rtci_state_t cur;
    rtci_state_t next_cur;
    logic [1:0] rst_pipe;
    logic rst_sync_n;
    logic per_tick;
    logic alm_match;
    logic [SRC_NUM-1:0] src_en;
    logic [SRC_NUM-1:0] src_evt;
    logic [SRC_NUM-1:0] src_clr;

    // -----------------------------------------------------------------
    // reset release
    // -----------------------------------------------------------------
    // assert at once, release on the clock to avoid recovery hazards
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // -----------------------------------------------------------------
    // periodic source
    // -----------------------------------------------------------------
    // runs only while enabled, so a fresh enable gives a full interval
    rtci_rate_gen #(
        .BASE_CYC(BASE_CYC)
    ) u_rate (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .run(periodic_en), // [R4]
        .rate_sel(rate_sel), // [R5]
        .tick(per_tick)
    );

    // -----------------------------------------------------------------
    // source events
    // -----------------------------------------------------------------
    // bcd bytes compare directly; no conversion so no rounding corners
    assign alm_match =
        rtci_alarm_match(time_now, alarm_time, alarm_care); // [R7]
    assign src_en = {update_en, periodic_en, alarm_en};
    assign src_clr = {update_clr, periodic_clr, alarm_clr};
    // alarm is judged the cycle after the update, on the new time
    assign src_evt =
        {update_strobe, per_tick, cur.alm_chk && alm_match}; // [R1] [R3] [R6]

    // pending flags and merged line; a set in the clear cycle wins
    always_comb begin
        next_cur = cur;
        next_cur.alm_chk = update_strobe; // [R3]
        for (int i = 0; i < SRC_NUM; i++) begin
            if (src_evt[i] && src_en[i]) begin
                next_cur.pend[i] = 1'b1; // [R9]
            end else if (src_clr[i]) begin
                next_cur.pend[i] = 1'b0; // [R9]
            end
        end
        next_cur.irq = |(next_cur.pend & src_en); // [R1] [R2]
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rtc_irq = cur.irq;
    assign alarm_pend = cur.pend[SRC_ALM];
    assign periodic_pend = cur.pend[SRC_PER];
    assign update_pend = cur.pend[SRC_UPD];

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    AST_UPD_SET: assert property (update_strobe && update_en |=> update_pend) // [R6]
        else $error("update event did not set its flag");
    AST_IRQ_MERGE: assert property (rtc_irq ==
        |({update_pend, periodic_pend, alarm_pend} & $past(src_en))) // [R2]
        else $error("interrupt line disagrees with enabled flags");
    AST_ALM_DIS: assert property ($rose(alarm_pend) |-> $past(alarm_en)) // [R2]
        else $error("disabled alarm raised its flag");
    AST_ALM_SET: assert property (
        update_strobe ##1 (alarm_en && alm_match) |=> alarm_pend) // [R3]
        else $error("alarm match missed");
    AST_ALM_CAUSE: assert property ($rose(alarm_pend) |->
        $past(update_strobe, 2) && $past(alm_match)) // [R3]
        else $error("alarm flag without a match after update");
    AST_SET_WINS: assert property (
        per_tick && periodic_en && periodic_clr |=> periodic_pend) // [R9]
        else $error("clear beat a periodic event");
    AST_UPD_CLR: assert property (update_clr &&
        !(update_strobe && update_en) |=> !update_pend) // [R9]
        else $error("update flag not cleared");
    AST_PER_SET: assert property (per_tick && periodic_en |=>
        periodic_pend && rtc_irq) // [R4]
        else $error("periodic tick did not set its flag");

    COV_ALM: cover property ($rose(alarm_pend) && rtc_irq);
    COV_PER: cover property ($rose(periodic_pend) && rtc_irq);
    COV_UPD: cover property ($rose(update_pend) && rtc_irq);
    COV_TWO: cover property (alarm_pend && update_pend && rtc_irq);
endmodule : rtci_top

/* tb/rtci_intc_model.sv */
// interrupt controller model: counts rising edges of the merged line
// assumes a level irq from a register on core_clk
`timescale 1ns/1ps
module rtci_intc_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic irq,
    output logic [7:0] edges
);
    logic last;

    // edge detect only; a level line stays high until the source clears
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= 1'b0;
            edges <= 8'h00;
        end else begin
            last <= irq;
            if (irq && !last) begin
                edges <= edges + 8'h01;
            end
        end
    end
endmodule : rtci_intc_model

/* tb/test_rtci_top.sv */
// self-checking bench for the rtc interrupt sources
// assumes rtci_top, rtci_pkg and the interrupt controller model
`timescale 1ns/1ps
module test_rtci_top import rtci_pkg::*;;
    localparam int BASE = 4; // short base interval keeps the run brief
    logic core_clk, rst_n, alarm_en, periodic_en, update_en;
    logic update_strobe, alarm_clr, periodic_clr, update_clr;
    logic [RATE_W-1:0] rate_sel;
    logic [FIELD_NUM*BCD_W-1:0] time_now, alarm_time;
    logic [FIELD_NUM-1:0] alarm_care;
    logic rtc_irq, alarm_pend, periodic_pend, update_pend, exp;
    logic [7:0] edges;
    int bad_count, num_checks, n;

    rtci_top #(.BASE_CYC(BASE)) u_dut (.core_clk(core_clk),
        .rst_n(rst_n), .alarm_en(alarm_en), .periodic_en(periodic_en),
        .update_en(update_en), .rate_sel(rate_sel),
        .update_strobe(update_strobe), .time_now(time_now),
        .alarm_time(alarm_time), .alarm_care(alarm_care),
        .alarm_clr(alarm_clr), .periodic_clr(periodic_clr),
        .update_clr(update_clr), .rtc_irq(rtc_irq),
        .alarm_pend(alarm_pend), .periodic_pend(periodic_pend),
        .update_pend(update_pend));
    rtci_intc_model u_intc (.core_clk(core_clk), .rst_n(rst_n),
        .irq(rtc_irq), .edges(edges));

    // free-running 100 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // inputs always move 1 ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic finish_test();
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic upd_pulse();
        update_strobe = 1'b1;
        step(1);
        update_strobe = 1'b0;
    endtask : upd_pulse

    task automatic clr_all();
        {alarm_clr, periodic_clr, update_clr} = 3'h7;
        step(1);
        {alarm_clr, periodic_clr, update_clr} = 3'h0;
    endtask : clr_all

    // bounded wait for a periodic flag; k counts the cycles waited
    task automatic wait_per(output int k);
        k = 0;
        while (periodic_pend !== 1'b1) begin
            step(1);
            k++;
            if (k > 2000) begin
                bad_count++;
                finish_test();
            end
        end
    endtask : wait_per

    // own model of the compare; an uncared field always matches
    function automatic logic want_hit(input logic [31:0] t,
        input logic [31:0] a, input logic [3:0] c);
        want_hit = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (c[i] && t[8*i+:8] != a[8*i+:8]) begin
                want_hit = 1'b0;
            end
        end
    endfunction : want_hit

    function automatic logic [7:0] rbcd();
        rbcd = {4'($urandom_range(5)), 4'($urandom_range(9))};
    endfunction : rbcd

    initial begin
        rst_n = 1'b0;
        {alarm_en, periodic_en, update_en, update_strobe} = 4'h0;
        {alarm_clr, periodic_clr, update_clr} = 3'h0;
        rate_sel = 4'h0;
        time_now = 32'h00000000;
        alarm_time = 32'h00000000;
        alarm_care = 4'h0;
        bad_count = 0;
        num_checks = 0;
        void'($urandom(3));
        step(16);
        rst_n = 1'b1;
        step(3);
        check({rtc_irq, alarm_pend, periodic_pend, update_pend}, 0);
        // update source: flag, merged line, enable drop, clear
        update_en = 1'b1;
        upd_pulse();
        check(update_pend, 1);
        check(rtc_irq, 1);
        step(1);
        check(edges, 8'h01);
        update_en = 1'b0;
        step(1);
        check(rtc_irq, 0);
        check(update_pend, 1);
        clr_all();
        check(update_pend, 0);
        upd_pulse();
        check(update_pend, 0);
        // clear and set together: the set has to win
        update_en = 1'b1;
        update_clr = 1'b1;
        upd_pulse();
        update_clr = 1'b0;
        check(update_pend, 1);
        update_en = 1'b0;
        clr_all();
        // alarm: random bcd times, corner masks first
        for (int i = 0; i < 24; i++) begin
            time_now = {rbcd(), rbcd(), rbcd(), rbcd()};
            alarm_time = time_now;
            if ($urandom_range(1) == 1) begin
                alarm_time[8*(i%4)+:8] = rbcd();
            end
            alarm_care = (i == 0) ? 4'h0 : (i == 1) ? 4'hf :
                4'($urandom_range(15));
            alarm_en = (i < 2) ? 1'b1 : 1'($urandom_range(1));
            exp = want_hit(time_now, alarm_time, alarm_care) & alarm_en;
            upd_pulse();
            step(1);
            check(alarm_pend, exp);
            check(rtc_irq, exp);
            clr_all();
        end
        alarm_en = 1'b0;
        // periodic: interval between flags follows the fixed rate table for rates 0 to 5
        for (int r = 0; r < 6; r++) begin
            rate_sel = 4'(r);
            periodic_en = 1'b1;
            wait_per(n);
            check(rtc_irq, 1);
            periodic_clr = 1'b1;
            step(1);
            periodic_clr = 1'b0;
            wait_per(n);
            check(n + 1, BASE << r);
            check({alarm_pend, update_pend}, 0);
            periodic_en = 1'b0;
            step(2);
            clr_all();
        end
        finish_test();
    end
endmodule : test_rtci_top
